//--- src/fb_pkg.sv
/*
  Constants, register map and state type of the fieldbus supervisor.
  Assumes a single 200 MHz clock and a plain register port.
*/
package fb_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_NODE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_EFFECTIVE = 8'h0c;
  localparam int CTRL_FB_CONTROL = 0;
  localparam int CTRL_INTERNAL = 1;
  localparam int CTRL_PARAM_BLOCK = 2;
  localparam int CTRL_TRIP_ON_LOSS = 3;
  localparam int CTRL_AUTO_CLEAR = 4;
  localparam int CTRL_TRIP_RESET = 5;
  localparam logic CTRL_FB_CONTROL_RST = 1'h0;
  localparam logic CTRL_INTERNAL_RST = 1'h0;
  localparam logic CTRL_PARAM_BLOCK_RST = 1'h0;
  localparam logic CTRL_TRIP_ON_LOSS_RST = 1'h0;
  localparam logic CTRL_AUTO_CLEAR_RST = 1'h0;
  localparam logic [7:0] NODE_RST = 8'hff;
  localparam logic [7:0] NODE_USE_PLUG = 8'hff;
  localparam int CLOCK_HZ = 200000000;
  localparam int TICK_TIME_MS = 1;
  localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_TIME_MS;
  localparam int HOLDOFF_TIME_S = 10;
  localparam int HOLDOFF_TICKS = HOLDOFF_TIME_S * 1000 / TICK_TIME_MS;
  localparam int SUPERVISION_TIME_MS = 500;
  localparam int SUPERVISION_TICKS = SUPERVISION_TIME_MS / TICK_TIME_MS;
  localparam int COUNT_W = 16;
  typedef enum logic [2:0] {
    st_off,
    st_online,
    st_holdoff,
    st_fallback,
    st_tripped
  } fb_state_t;
endpackage

//--- src/sync2.sv
/*
  Two-flop synchroniser for pin inputs.
  Assumes the synchronous reset copy of the design.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      q <= '0;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule

//--- src/tick_divider.sv
/*
  Divider giving a one-cycle enable pulse every CYCLES clocks.
  Assumes a single clock domain.
*/
`timescale 1ns/1ps
module tick_divider #(
  parameter int CYCLES = 200000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Enable pulse
  output logic tick
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] count;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (count == LAST);
      count <= (count == LAST) ? '0 : count + W'(1);
    end
  end
endmodule

//--- src/fieldbus_supervisor.sv
/*
  Fieldbus control and fault supervisor of a motor starter.
  Assumes a plug receiver on the same clock that flags good frames and
  commands, and plug pins and local inputs that need synchronising.
*/
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module fieldbus_supervisor #(
  parameter int TICK_CYCLES = fb_pkg::TICK_CYCLES,
  parameter int HOLDOFF_TICKS = fb_pkg::HOLDOFF_TICKS,
  parameter int SUPERVISION_TICKS = fb_pkg::SUPERVISION_TICKS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Plug pins
  input wire logic plug_present,
  input wire logic [7:0] plug_address,
  // Plug receiver
  input wire logic link_frame_ok,
  input wire logic fb_cmd_valid,
  input wire logic fb_cmd_start,
  input wire logic fb_cmd_stop,
  input wire logic fb_read_req,
  input wire logic fb_param_req,
  output logic fb_cmd_taken,
  output logic fb_read_ack,
  output logic fb_param_ack,
  // Local hard-wired inputs
  input wire logic local_start,
  input wire logic local_stop,
  // Status and control out
  output logic motor_run,
  output logic trip,
  output logic fieldbus_in_control,
  output logic comm_enabled,
  output logic iface_reset,
  output logic internal_modbus_on,
  output logic [7:0] node_address_used
);
  localparam logic [15:0] HOLD_LAST = 16'(HOLDOFF_TICKS);
  localparam logic [15:0] SUP_LAST = 16'(SUPERVISION_TICKS);

  logic rst_q1;
  logic rst_n;
  logic tick;
  logic plug_s;
  logic [7:0] plug_addr_s;
  logic local_start_s;
  logic local_stop_s;
  logic control_on;
  logic internal_sel;
  logic param_load_blocked;
  logic trip_on_loss;
  logic auto_clear;
  logic trip_reset_req;
  logic [7:0] node;
  logic [15:0] link_age;
  logic [15:0] hold_count;
  logic lost;
  logic holdoff_done;
  logic wr_ctrl;
  logic wr_node;
  fb_pkg::fb_state_t state;
  fb_pkg::fb_state_t next_state;

  // Reset release
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  sync2 #(.WIDTH(11)) pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({plug_present, plug_address, local_start, local_stop}),
    .q({plug_s, plug_addr_s, local_start_s, local_stop_s})
  );

  tick_divider #(.CYCLES(TICK_CYCLES)) ms_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  assign wr_ctrl = reg_write && hit(reg_addr, fb_pkg::ADDR_CTRL);
  assign wr_node = reg_write && hit(reg_addr, fb_pkg::ADDR_NODE);

  // Control settings
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_on <= fb_pkg::CTRL_FB_CONTROL_RST;
      internal_sel <= fb_pkg::CTRL_INTERNAL_RST;
      param_load_blocked <= fb_pkg::CTRL_PARAM_BLOCK_RST;
      trip_on_loss <= fb_pkg::CTRL_TRIP_ON_LOSS_RST;
      auto_clear <= fb_pkg::CTRL_AUTO_CLEAR_RST;
    end
    else if (wr_ctrl)
    begin
      control_on <= reg_wdata[fb_pkg::CTRL_FB_CONTROL];
      internal_sel <= reg_wdata[fb_pkg::CTRL_INTERNAL];
      param_load_blocked <= reg_wdata[fb_pkg::CTRL_PARAM_BLOCK];
      if (control_on)
      begin
        trip_on_loss <= reg_wdata[fb_pkg::CTRL_TRIP_ON_LOSS];
      end
      if (control_on && trip_on_loss)
      begin
        auto_clear <= reg_wdata[fb_pkg::CTRL_AUTO_CLEAR];
      end
    end
  end

  // Manual trip reset pulse
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trip_reset_req <= 1'b0;
    end
    else
    begin
      trip_reset_req <= wr_ctrl && reg_wdata[fb_pkg::CTRL_TRIP_RESET];
    end
  end

  // Node address and interface reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      node <= fb_pkg::NODE_RST;
      iface_reset <= 1'b0;
    end
    else
    begin
      iface_reset <= wr_node && (reg_wdata[7:0] != node);
      if (wr_node)
      begin
        node <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      node_address_used <= fb_pkg::NODE_RST;
    end
    else
    begin
      node_address_used <= (node == fb_pkg::NODE_USE_PLUG) ? plug_addr_s : node;
    end
  end

  assign comm_enabled = plug_s || internal_sel;
  assign internal_modbus_on = internal_sel;

  // Link supervision
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_age <= '0;
    end
    else if (link_frame_ok || iface_reset)
    begin
      link_age <= '0;
    end
    else if (tick && link_age < SUP_LAST)
    begin
      link_age <= link_age + 16'h0001;
    end
  end

  assign lost = !comm_enabled || (link_age >= SUP_LAST);

  // Hold-off timer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_count <= '0;
    end
    else if (state != fb_pkg::st_holdoff)
    begin
      hold_count <= '0;
    end
    else if (tick && hold_count < HOLD_LAST)
    begin
      hold_count <= hold_count + 16'h0001;
    end
  end

  assign holdoff_done = (hold_count >= HOLD_LAST);

  // Supervision state
  always_comb
  begin
    next_state = state;
    case (state)
      fb_pkg::st_off:
      begin
        if (control_on)
        begin
          if (!lost)
          begin
            next_state = fb_pkg::st_online;
          end
          else
          begin
            next_state = trip_on_loss ? fb_pkg::st_tripped : fb_pkg::st_fallback;
          end
        end
      end
      fb_pkg::st_online, fb_pkg::st_holdoff:
      begin
        if (!control_on)
        begin
          next_state = fb_pkg::st_off;
        end
        else if (lost)
        begin
          next_state = trip_on_loss ? fb_pkg::st_tripped : fb_pkg::st_fallback;
        end
        else if (state == fb_pkg::st_holdoff && holdoff_done)
        begin
          next_state = fb_pkg::st_online;
        end
      end
      fb_pkg::st_fallback:
      begin
        if (!control_on)
        begin
          next_state = fb_pkg::st_off;
        end
        else if (!lost)
        begin
          next_state = fb_pkg::st_holdoff;
        end
      end
      fb_pkg::st_tripped:
      begin
        if ((auto_clear && !lost) || (!auto_clear && trip_reset_req))
        begin
          next_state = control_on ? fb_pkg::st_holdoff : fb_pkg::st_off;
        end
      end
      default:
      begin
        next_state = fb_pkg::st_off;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= fb_pkg::st_off;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign fb_cmd_taken = fb_cmd_valid && control_on && (state == fb_pkg::st_online);
  assign fb_read_ack = fb_read_req && comm_enabled;
  assign fb_param_ack = fb_param_req && comm_enabled && !param_load_blocked;
  assign trip = (state == fb_pkg::st_tripped);
  assign fieldbus_in_control = (state == fb_pkg::st_online) || (state == fb_pkg::st_holdoff);

  // Motor command
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      motor_run <= 1'b0;
    end
    else
    begin
      case (state)
        fb_pkg::st_tripped:
        begin
          motor_run <= 1'b0;
        end
        fb_pkg::st_online:
        begin
          if (fb_cmd_taken && fb_cmd_stop)
          begin
            motor_run <= 1'b0;
          end
          else if (fb_cmd_taken && fb_cmd_start)
          begin
            motor_run <= 1'b1;
          end
        end
        fb_pkg::st_off, fb_pkg::st_fallback:
        begin
          if (local_stop_s)
          begin
            motor_run <= 1'b0;
          end
          else if (local_start_s)
          begin
            motor_run <= 1'b1;
          end
        end
        default:
        begin
          motor_run <= motor_run;
        end
      endcase
    end
  end

  // Register read, data one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= '0;
    end
    else if (reg_read)
    begin
      reg_rdata <= '0;
      if (hit(reg_addr, fb_pkg::ADDR_CTRL))
      begin
        reg_rdata[fb_pkg::CTRL_FB_CONTROL] <= control_on;
        reg_rdata[fb_pkg::CTRL_INTERNAL] <= internal_sel;
        reg_rdata[fb_pkg::CTRL_PARAM_BLOCK] <= param_load_blocked;
        reg_rdata[fb_pkg::CTRL_TRIP_ON_LOSS] <= control_on && trip_on_loss;
        reg_rdata[fb_pkg::CTRL_AUTO_CLEAR] <= control_on && trip_on_loss && auto_clear;
      end
      else if (hit(reg_addr, fb_pkg::ADDR_NODE))
      begin
        reg_rdata[7:0] <= node;
      end
      else if (hit(reg_addr, fb_pkg::ADDR_STATUS))
      begin
        reg_rdata[7:0] <= {plug_s, motor_run, lost, state == fb_pkg::st_holdoff,
          trip, state == fb_pkg::st_fallback, fieldbus_in_control, comm_enabled};
      end
      else if (hit(reg_addr, fb_pkg::ADDR_EFFECTIVE))
      begin
        reg_rdata[7:0] <= node_address_used;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence trip_with_link_back;
    (state == fb_pkg::st_tripped) && auto_clear && !lost;
  endsequence

  sequence node_changed;
    wr_node && (reg_wdata[7:0] != node);
  endsequence

  cmd_gate_a: assert property (fb_cmd_taken |-> control_on)
    else $error("command taken with fieldbus control off");
  read_serve_a: assert property (fb_read_req && comm_enabled |-> fb_read_ack)
    else $error("fieldbus read not served");
  plug_enable_a: assert property ($rose(plug_s) |-> comm_enabled)
    else $error("plug attached but communication disabled");
  plug_address_a: assert property (node == 8'hff && $stable(plug_addr_s) |=> node_address_used == $past(plug_addr_s))
    else $error("plug address not used at node 255");
  iface_reset_a: assert property (node_changed |=> iface_reset ##1 !iface_reset)
    else $error("interface reset pulse missing on address change");
  trip_latch_a: assert property (trip && !auto_clear && !trip_reset_req |=> trip)
    else $error("manual trip cleared without reset");
  fallback_a: assert property (state == fb_pkg::st_online && control_on && lost && !trip_on_loss
    |=> state == fb_pkg::st_fallback)
    else $error("no fallback to local control on link loss");
  recover_a: assert property (state == fb_pkg::st_fallback && control_on && !lost
    |=> state == fb_pkg::st_holdoff)
    else $error("control not handed back after recovery");
  holdoff_block_a: assert property (state == fb_pkg::st_holdoff |-> !fb_cmd_taken ##1 $stable(motor_run))
    else $error("command taken during hold-off");
  holdoff_length_a: assert property (state == fb_pkg::st_online && $past(state) == fb_pkg::st_holdoff
    |-> $past(hold_count) >= HOLD_LAST)
    else $error("hold-off ended early");
  trip_stop_a: assert property (trip ##1 trip |-> !motor_run)
    else $error("motor running while tripped");
  auto_clear_a: assert property (trip_with_link_back |=> !trip)
    else $error("automatic trip clear missing");
endmodule

//--- sim/plug_model.sv
/*
  Behavioural fieldbus plug adapter facing the supervisor's receiver side.
  Assumes the supervisor's clock; the bench steers attach, framing and requests.
*/
`timescale 1ns/1ps
module plug_model #(
  parameter int FRAME_GAP = 20,
  parameter int RETRIES = 3
) (
  // Clock and steering
  input wire logic clock,
  input wire logic attach,
  input wire logic frames_on,
  input wire logic [7:0] stored_address,
  // Plug pins
  output logic plug_present,
  output logic [7:0] plug_address,
  // Receiver side
  output logic link_frame_ok,
  output logic fb_cmd_valid,
  output logic fb_cmd_start,
  output logic fb_cmd_stop,
  output logic fb_read_req,
  output logic fb_param_req,
  input wire logic fb_cmd_taken,
  input wire logic fb_read_ack,
  input wire logic fb_param_ack
);
  int gap = 0;
  initial
  begin
    link_frame_ok = 1'b0;
    fb_cmd_valid = 1'b0;
    fb_cmd_start = 1'b0;
    fb_cmd_stop = 1'b0;
    fb_read_req = 1'b0;
    fb_param_req = 1'b0;
  end
  // Detached pins no longer show the stored address
  assign plug_present = attach;
  assign plug_address = attach ? stored_address : ~stored_address;
  always @(posedge clock)
  begin
    gap <= (frames_on && gap < FRAME_GAP - 1) ? gap + 1 : 0;
    link_frame_ok <= frames_on && (gap == FRAME_GAP - 1);
  end
  task automatic send_cmd(input logic start, input logic stop, output logic taken);
    @(posedge clock);
    fb_cmd_valid <= 1'b1;
    fb_cmd_start <= start;
    fb_cmd_stop <= stop;
    #1 taken = fb_cmd_taken;
    @(posedge clock);
    fb_cmd_valid <= 1'b0;
    fb_cmd_start <= 1'b0;
    fb_cmd_stop <= 1'b0;
  endtask
  // Repeats a failed read, then gives the slave up as absent
  task automatic read_data(output logic present);
    present = 1'b0;
    for (int i = 0; i < RETRIES && !present; i++)
    begin
      @(posedge clock);
      fb_read_req <= 1'b1;
      #1 present = fb_read_ack;
      @(posedge clock);
      fb_read_req <= 1'b0;
    end
  endtask
  task automatic send_param(output logic ack);
    @(posedge clock);
    fb_param_req <= 1'b1;
    #1 ack = fb_param_ack;
    @(posedge clock);
    fb_param_req <= 1'b0;
  endtask
endmodule

//--- sim/fieldbus_supervisor_tb.sv
/*
  Self-checking bench of the fieldbus supervisor with shortened counts.
  Assumes plug_model on the receiver side and the plain register port.
*/
`timescale 1ns/1ps
module fieldbus_supervisor_tb;
  logic clock, arst_n, reg_write, reg_read, local_start, local_stop, attach, frames_on, ok;
  logic [7:0] reg_addr, plug_address, node_address_used;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic plug_present, link_frame_ok, fb_cmd_valid, fb_cmd_start, fb_cmd_stop, fb_read_req;
  logic fb_param_req, fb_cmd_taken, fb_read_ack, fb_param_ack, motor_run, trip;
  logic fieldbus_in_control, comm_enabled, iface_reset, internal_modbus_on;
  int n_mismatch = 0;
  int checks_done = 0;
  fieldbus_supervisor #(.TICK_CYCLES(10), .HOLDOFF_TICKS(20), .SUPERVISION_TICKS(5)) i_dut (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .plug_present(plug_present), .plug_address(plug_address), .link_frame_ok(link_frame_ok),
    .fb_cmd_valid(fb_cmd_valid), .fb_cmd_start(fb_cmd_start), .fb_cmd_stop(fb_cmd_stop),
    .fb_read_req(fb_read_req), .fb_param_req(fb_param_req), .fb_cmd_taken(fb_cmd_taken),
    .fb_read_ack(fb_read_ack), .fb_param_ack(fb_param_ack), .local_start(local_start),
    .local_stop(local_stop), .motor_run(motor_run), .trip(trip),
    .fieldbus_in_control(fieldbus_in_control), .comm_enabled(comm_enabled),
    .iface_reset(iface_reset), .internal_modbus_on(internal_modbus_on),
    .node_address_used(node_address_used));
  plug_model i_plug (
    .clock(clock), .attach(attach), .frames_on(frames_on), .stored_address(8'h5a),
    .plug_present(plug_present), .plug_address(plug_address), .link_frame_ok(link_frame_ok),
    .fb_cmd_valid(fb_cmd_valid), .fb_cmd_start(fb_cmd_start), .fb_cmd_stop(fb_cmd_stop),
    .fb_read_req(fb_read_req), .fb_param_req(fb_param_req), .fb_cmd_taken(fb_cmd_taken),
    .fb_read_ack(fb_read_ack), .fb_param_ack(fb_param_ack));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rdreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wr_node(input logic [7:0] v, input logic [7:0] used);
    int n;
    n = 0;
    wr(fb_pkg::ADDR_NODE, {24'h0, v});
    repeat (3)
    begin
      #1 n += int'(iface_reset);
      @(posedge clock);
    end
    chk("iface reset pulses", 32'h1, n);
    #1 chk("address used", {24'h0, used}, {24'h0, node_address_used});
  endtask
  task automatic wait_flag(input logic sel, input logic want, input int limit, input string what);
    logic cur;
    cur = ~want;
    for (int i = 0; i < limit && cur !== want; i++)
    begin
      @(posedge clock);
      #1 cur = sel ? trip : fieldbus_in_control;
    end
    chk(what, want, cur);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic t_reset;
    rdreg(fb_pkg::ADDR_CTRL, rd);
    chk("ctrl reset", 32'h0, rd);
    rdreg(fb_pkg::ADDR_NODE, rd);
    chk("node reset", 32'hff, rd);
    rdreg(fb_pkg::ADDR_EFFECTIVE, rd);
    chk("plug address", 32'h5a, rd);
    rdreg(8'h10, rd);
    chk("unmapped read", 32'h0, rd);
    $display("test reset done");
  endtask
  task automatic t_monitor;
    chk("comm with plug", 1'b1, comm_enabled);
    i_plug.read_data(ok);
    chk("read served", 1'b1, ok);
    i_plug.send_cmd(1'b1, 1'b0, ok);
    chk("cmd while off", 1'b0, ok);
    #1 chk("motor idle", 1'b0, motor_run);
    wr(fb_pkg::ADDR_CTRL, 32'h18);
    rdreg(fb_pkg::ADDR_CTRL, rd);
    chk("hidden reaction", 32'h0, rd);
    $display("test monitor done");
  endtask
  task automatic t_node;
    wr_node(8'h12, 8'h12);
    rdreg(fb_pkg::ADDR_NODE, rd);
    chk("node readback", 32'h12, rd);
    wr(fb_pkg::ADDR_CTRL, 32'h1);
    wr_node(8'h00, 8'h00);
    wr_node(8'hff, 8'h5a);
    wr(fb_pkg::ADDR_CTRL, 32'h0);
    $display("test node done");
  endtask
  task automatic t_type;
    @(posedge clock);
    attach <= 1'b0;
    pause(4);
    #1 chk("no plug", 1'b0, comm_enabled);
    i_plug.read_data(ok);
    chk("slave absent", 1'b0, ok);
    wr(fb_pkg::ADDR_CTRL, 32'h2);
    #1 chk("internal on", 1'b1, internal_modbus_on);
    chk("internal comm", 1'b1, comm_enabled);
    i_plug.send_param(ok);
    chk("download allowed", 1'b1, ok);
    wr(fb_pkg::ADDR_CTRL, 32'h6);
    i_plug.send_param(ok);
    chk("download blocked", 1'b0, ok);
    wr(fb_pkg::ADDR_CTRL, 32'h0);
    attach <= 1'b1;
    pause(4);
    $display("test type done");
  endtask
  task automatic t_fallback;
    wr(fb_pkg::ADDR_CTRL, 32'h1);
    wait_flag(1'b0, 1'b1, 60, "control on");
    i_plug.send_cmd(1'b1, 1'b0, ok);
    chk("start taken", 1'b1, ok);
    #1 chk("motor runs", 1'b1, motor_run);
    frames_on <= 1'b0;
    wait_flag(1'b0, 1'b0, 100, "fallback");
    chk("no trip", 1'b0, trip);
    rdreg(fb_pkg::ADDR_STATUS, rd);
    chk("fallback status", 32'h4, rd & 32'h6);
    @(posedge clock);
    local_stop <= 1'b1;
    pause(6);
    local_stop <= 1'b0;
    local_start <= 1'b1;
    #1 chk("local stop", 1'b0, motor_run);
    pause(6);
    local_start <= 1'b0;
    #1 chk("local start", 1'b1, motor_run);
    i_plug.send_cmd(1'b0, 1'b1, ok);
    chk("cmd in fallback", 1'b0, ok);
    frames_on <= 1'b1;
    wait_flag(1'b0, 1'b1, 60, "control back");
    pause(100);
    i_plug.send_cmd(1'b0, 1'b1, ok);
    chk("cmd in holdoff", 1'b0, ok);
    pause(150);
    i_plug.send_cmd(1'b0, 1'b1, ok);
    chk("cmd after holdoff", 1'b1, ok);
    #1 chk("motor stopped", 1'b0, motor_run);
    $display("test fallback done");
  endtask
  task automatic t_trip;
    wr(fb_pkg::ADDR_CTRL, 32'h11);
    rdreg(fb_pkg::ADDR_CTRL, rd);
    chk("hidden reset mode", 32'h1, rd);
    wr(fb_pkg::ADDR_CTRL, 32'h9);
    rdreg(fb_pkg::ADDR_CTRL, rd);
    chk("reaction shown", 32'h9, rd);
    i_plug.send_cmd(1'b1, 1'b0, ok);
    frames_on <= 1'b0;
    wait_flag(1'b1, 1'b1, 100, "trip on loss");
    @(posedge clock);
    #1 chk("trip stops motor", 1'b0, motor_run);
    frames_on <= 1'b1;
    pause(100);
    #1 chk("trip latched", 1'b1, trip);
    wr(fb_pkg::ADDR_CTRL, 32'h29);
    wait_flag(1'b1, 1'b0, 5, "manual clear");
    wr(fb_pkg::ADDR_CTRL, 32'h19);
    rdreg(fb_pkg::ADDR_CTRL, rd);
    chk("reset mode shown", 32'h19, rd);
    frames_on <= 1'b0;
    wait_flag(1'b1, 1'b1, 100, "auto trip");
    frames_on <= 1'b1;
    wait_flag(1'b1, 1'b0, 60, "auto clear");
    $display("test trip done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #50000;
    n_mismatch++;
    print_verdict;
  end
  initial
  begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    local_start = 1'b0;
    local_stop = 1'b0;
    attach = 1'b1;
    frames_on = 1'b1;
    arst_n = 1'b0;
    pause(6);
    arst_n <= 1'b1;
    pause(3);
    t_reset;
    t_monitor;
    t_node;
    t_type;
    t_fallback;
    t_trip;
    print_verdict;
  end
endmodule
